// ==== core/flowthrough_burst_sram_pkg.sv ====
// Shared constants and types for the flow-through burst SRAM port
package flowthrough_burst_sram_pkg;

   localparam int ADDR_W   = 21;       // Word address width
   localparam int DATA_W   = 18;       // Data bus width
   localparam int LANE_W   = 9;        // Bits per byte lane
   localparam int LANES    = 2;        // Byte lanes
   localparam int BURST_W  = 2;        // Burst counter width, four beats

   localparam logic [BURST_W-1:0] CNT_ZERO = 2'h0;  // First beat
   localparam logic [BURST_W-1:0] CNT_STEP = 2'h1;  // Advance step

   // Reset values of the asynchronous-pin synchronisers
   localparam logic OE_N_RST  = 1'b1;  // Output enable inactive
   localparam logic SNZ_RST   = 1'b0;  // Snooze off
   localparam logic ORDER_RST = 1'b1;  // Interleaved, as with the pull-up

   // Access mode, one-hot
   typedef enum logic [3:0] {
      MODE_DESEL  = 4'h1,
      MODE_READ   = 4'h2,
      MODE_WRITE  = 4'h4,
      MODE_SNOOZE = 4'h8
   } access_mode_t;

   // Burst address state
   typedef struct packed {
      logic [ADDR_W-1:0]  base;       // Captured start address
      logic [BURST_W-1:0] cnt;        // Beat count within burst
   } burst_state_t;

   // Asynchronous pins after synchronising
   typedef struct packed {
      logic oe_n;                     // Output enable, active low
      logic snooze;                   // Snooze request
      logic order;                    // 1 interleaved, 0 linear
   } async_pins_t;

endpackage

// ==== core/flowthrough_burst_sram_port.sv ====
// Flow-through burst synchronous SRAM: control, burst logic and array
//
// Overview of operation
// R1: Sync inputs on edge; OE, snooze, order async
// R2: Capture address when enabled and strobe asserted
// R3: Master enable inactive blocks processor strobe
// R4: Secondary enables high/low, sampled with strobes
// R5: Strobe low loads address or deselects
// R6: Advance low continues burst to next address
// R7: Global write low writes all bits
// R8: Byte gate low writes lanes with enable low
// R9: Drive data only when selected, reading, enabled
// R10: Order select high interleaved, low linear
// R11: Four-beat bursts, XOR or modulo-four increment
// R12: Snooze high enters low power, keeps data
// R13: Snooze deselects, ignores inputs, outputs high-Z
// R14: Controller finishes operations before raising snooze
// R15: Only deselect or reads during snooze exit
// R16: Controller drops OE before write after read
// R17: Increment burst address when advance low, strobes high
// R18: Processor strobe high when controller strobe starts
// R19: Write controls ignored on processor-strobe start
// R20: Sampled byte write disables drivers, latches data
// R21: No strobe, advance high holds current address
`timescale 1ns/10ps
`default_nettype none

module flowthrough_burst_sram_port #(
   parameter int ADDR_W = flowthrough_burst_sram_pkg::ADDR_W,
   parameter int LANE_W = flowthrough_burst_sram_pkg::LANE_W,
   parameter int LANES  = flowthrough_burst_sram_pkg::LANES
) (
   input  wire logic                        ref_clk,
   input  wire logic                        srst,
   input  wire logic [ADDR_W-3:0]           addr_hi,
   input  wire logic                        burst_addr_bit1,
   input  wire logic                        burst_addr_bit0,
   input  wire logic                        master_chip_en_n,
   input  wire logic                        chip_en_hi,
   input  wire logic                        chip_en_lo_n,
   input  wire logic                        proc_addr_strobe_n,
   input  wire logic                        ctrl_addr_strobe_n,
   input  wire logic                        burst_advance_n,
   input  wire logic                        all_bytes_write_n,
   input  wire logic                        byte_write_gate_n,
   input  wire logic [LANES-1:0]            byte_lane_write_n,
   input  wire logic                        output_en_n,
   input  wire logic                        burst_order_sel,
   input  wire logic                        snooze_req,
   input  wire logic [LANES*LANE_W-1:0]     dq_in,
   output logic      [LANES*LANE_W-1:0]     dq_out,
   output logic                             dq_oe,
   output logic                             snooze_active
);

   localparam int BW    = flowthrough_burst_sram_pkg::BURST_W;
   localparam int DEPTH = 2 ** ADDR_W;

   // Two-stage synchronisers for the clockless pins
   flowthrough_burst_sram_pkg::async_pins_t sync1_q, sync1_d;   // First stage only
   flowthrough_burst_sram_pkg::async_pins_t pins_q,  pins_d;    // Safe to use

   // Burst and mode state
   flowthrough_burst_sram_pkg::burst_state_t burst_q, burst_d;
   flowthrough_burst_sram_pkg::access_mode_t mode_q,  mode_d;
   logic                     dq_oe_q, dq_oe_d;        // Driver enable
   logic                     snz_q,   snz_d;          // Snooze indicator

   // Decode terms
   logic                     en_all;                  // All enables active
   logic                     proc_go;                 // Processor strobe taken
   logic                     ctrl_go;                 // Controller strobe taken
   logic                     load;                    // New address this edge
   logic [LANES-1:0]         wr_lanes;                // Lanes asked to write
   logic [LANES-1:0]         wr_en;                   // Lanes written this edge
   logic [BW-1:0]            acc_lo;                  // Burst-ordered low bits
   logic [ADDR_W-1:0]        acc_addr;                // Address accessed this edge

   // Synchroniser next values
   always_comb begin
      sync1_d = '{oe_n: output_en_n, snooze: snooze_req, order: burst_order_sel}; // R1
      pins_d  = sync1_q;
   end

   // Command decode and next burst state
   always_comb begin
      en_all  = ~master_chip_en_n & chip_en_hi & ~chip_en_lo_n;          // R4
      proc_go = ~proc_addr_strobe_n & ~master_chip_en_n;                 // R3
      // Controller strobe counts when the processor one is high or blocked
      ctrl_go = ~ctrl_addr_strobe_n & ~proc_go;                          // R18
      load    = (proc_go | ctrl_go) & en_all;                            // R2
      // Global write overrides the byte gate and lane enables
      if (!all_bytes_write_n) begin
         wr_lanes = '1;                                                  // R7
      end else if (!byte_write_gate_n) begin
         wr_lanes = ~byte_lane_write_n;                                  // R8
      end else begin
         wr_lanes = '0;                                                  // R8
      end
      burst_d = burst_q;
      mode_d  = mode_q;
      snz_d   = pins_q.snooze;
      if (pins_q.snooze) begin
         // Everything but the snooze pin is ignored
         mode_d = flowthrough_burst_sram_pkg::MODE_SNOOZE;               // R13
      end else if (proc_go | ctrl_go) begin
         if (en_all) begin
            burst_d.base = {addr_hi, burst_addr_bit1, burst_addr_bit0};  // R2
            burst_d.cnt  = flowthrough_burst_sram_pkg::CNT_ZERO;
            // Processor-strobe starts ignore write controls
            mode_d = (ctrl_go && (|wr_lanes)) ?
                     flowthrough_burst_sram_pkg::MODE_WRITE :
                     flowthrough_burst_sram_pkg::MODE_READ;              // R19
         end else begin
            mode_d = flowthrough_burst_sram_pkg::MODE_DESEL;             // R5
         end
      end else if (mode_q == flowthrough_burst_sram_pkg::MODE_READ ||
                   mode_q == flowthrough_burst_sram_pkg::MODE_WRITE) begin
         if (!burst_advance_n) begin
            burst_d.cnt = burst_q.cnt + flowthrough_burst_sram_pkg::CNT_STEP; // R17
         end
         // Advance high keeps the count, so the same word is accessed again
         mode_d = (|wr_lanes) ? flowthrough_burst_sram_pkg::MODE_WRITE :
                                flowthrough_burst_sram_pkg::MODE_READ;   // R6 R21
      end else begin
         // Snooze exit and idle both settle deselected
         mode_d = flowthrough_burst_sram_pkg::MODE_DESEL;
      end
      // Order pin high interleaves, low counts linearly
      if (pins_q.order) begin
         acc_lo = burst_d.base[BW-1:0] ^ burst_d.cnt;                    // R10 R11
      end else begin
         acc_lo = burst_d.base[BW-1:0] + burst_d.cnt;                    // R11
      end
      acc_addr = {burst_d.base[ADDR_W-1:BW], acc_lo};
      wr_en    = (mode_d == flowthrough_burst_sram_pkg::MODE_WRITE) ? wr_lanes : '0; // R20
      // Drivers only for a selected read with output enable low
      dq_oe_d  = (mode_d == flowthrough_burst_sram_pkg::MODE_READ) &
                 ~pins_q.oe_n & ~pins_q.snooze;                          // R9 R20
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync1_q <= '{oe_n: flowthrough_burst_sram_pkg::OE_N_RST,
                      snooze: flowthrough_burst_sram_pkg::SNZ_RST,
                      order: flowthrough_burst_sram_pkg::ORDER_RST};
         pins_q  <= '{oe_n: flowthrough_burst_sram_pkg::OE_N_RST,
                      snooze: flowthrough_burst_sram_pkg::SNZ_RST,
                      order: flowthrough_burst_sram_pkg::ORDER_RST};
         burst_q <= '0;
         mode_q  <= flowthrough_burst_sram_pkg::MODE_DESEL;
         dq_oe_q <= 1'b0;
         snz_q   <= flowthrough_burst_sram_pkg::SNZ_RST;
      end else begin
         sync1_q <= sync1_d;
         pins_q  <= pins_d;
         burst_q <= burst_d;
         mode_q  <= mode_d;
         dq_oe_q <= dq_oe_d;
         snz_q   <= snz_d;
      end
   end

   // One array per byte lane; contents survive snooze and reset
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [DEPTH];                // Stored lane data
      always_ff @(posedge ref_clk) begin
         if (wr_en[i]) begin
            lane_mem[acc_addr] <= dq_in[i*LANE_W +: LANE_W];               // R20 R12
         end
         // Read-before-write; drivers are off on write edges anyway
         dq_out[i*LANE_W +: LANE_W] <= lane_mem[acc_addr];
      end
   end

   assign dq_oe         = dq_oe_q;
   assign snooze_active = snz_q;

   // Checks on the design's own behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   snooze_hiz_a: assert property (pins_q.snooze |=> !dq_oe_q && // R13
      mode_q == flowthrough_burst_sram_pkg::MODE_SNOOZE) else $error("drive in snooze");
   write_off_a: assert property (|wr_en |=> !dq_oe_q) // R20
      else $error("driving during write");
   drive_read_a: assert property (dq_oe_q |-> // R9
      mode_q == flowthrough_burst_sram_pkg::MODE_READ) else $error("drive outside read");
   proc_read_a: assert property (!pins_q.snooze && proc_go && en_all |=> // R19
      mode_q == flowthrough_burst_sram_pkg::MODE_READ) else $error("proc start not read");
   addr_load_a: assert property (!pins_q.snooze && load |=> // R2
      burst_q.base == $past({addr_hi, burst_addr_bit1, burst_addr_bit0})
      && burst_q.cnt == flowthrough_burst_sram_pkg::CNT_ZERO) else $error("address lost");
   blocked_desel_a: assert property (!pins_q.snooze && master_chip_en_n && // R3
      !ctrl_addr_strobe_n |=> mode_q == flowthrough_burst_sram_pkg::MODE_DESEL)
      else $error("no deselect");
   burst_step_a: assert property (!pins_q.snooze && !load && !burst_advance_n && // R17
      mode_q inside {flowthrough_burst_sram_pkg::MODE_READ,
                     flowthrough_burst_sram_pkg::MODE_WRITE} && !(proc_go | ctrl_go)
      |=> burst_q.cnt == $past(burst_q.cnt) + 2'h1) else $error("burst not advanced");
   burst_hold_a: assert property (!pins_q.snooze && burst_advance_n && // R21
      !(proc_go | ctrl_go) |=> $stable(burst_q)) else $error("burst moved");
   global_wr_a: assert property (!pins_q.snooze && ctrl_go && en_all && // R7
      !all_bytes_write_n |-> wr_en == '1) else $error("global write partial");
   order_a: assert property (pins_q.order |-> // R11
      acc_lo == (burst_d.base[BW-1:0] ^ burst_d.cnt)) else $error("bad interleave");

endmodule

`default_nettype wire

// ==== tb/sram_bus_partner.sv ====
// Far-side controller model: owns the shared data wire and flags driver overlap
`timescale 1ns/10ps
`default_nettype none
module sram_bus_partner (
   input  wire logic        ref_clk,
   input  wire logic        dq_oe,
   input  wire logic [17:0] dq_out,
   input  wire logic        drv_en,
   input  wire logic [17:0] drv_data,
   output logic      [17:0] dq_wire,
   output logic             clash
);
   logic [17:0] float_q = 18'h2AAAA;  // Released bus toggles, never a stale value
   initial clash = 1'b0;
   // Idle pattern changes every cycle; any overlap of the two drivers is sticky
   always @(posedge ref_clk) begin
      float_q <= ~float_q;
      if (dq_oe && drv_en) clash <= 1'b1;
   end
   // Controller drives only write data, and only once the device has let go
   assign dq_wire = dq_oe ? dq_out : (drv_en ? drv_data : float_q);
endmodule
`default_nettype wire

// ==== tb/flowthrough_burst_sram_port_bench.sv ====
// Self-checking bench for the flow-through burst SRAM port
`timescale 1ns/10ps
`default_nettype none
module flowthrough_burst_sram_port_bench;
   localparam logic [2:0] EN = 3'h2;         // Master low, high enable high, low enable low
   logic        ref_clk = 1'b0, srst = 1'b1;  // Clock and reset
   logic [3:0]  ah = 4'h0;                    // Upper word address
   logic        a1 = 1'b0, a0 = 1'b0, m_n = 1'b1, hi = 1'b0, lo_n = 1'b1;
   logic        p_n = 1'b1, c_n = 1'b1, adv_n = 1'b1, gw_n = 1'b1, bg_n = 1'b1;
   logic [1:0]  ln_n = 2'h3;                  // Lane write enables
   logic        oe_n = 1'b0, order = 1'b1, snz = 1'b0, drv_en = 1'b0, clash;
   logic [17:0] drv_d = 18'h0, dq_w, dq_out;  // Bus values
   logic        dq_oe, snz_act;
   logic [17:0] mem [64];                     // Expected array content
   logic [31:0] rnd = 32'hC367;               // Fixed-seed random source
   logic [5:0]  base;
   logic [1:0]  st;
   int          n_fail = 0, check_count = 0;
   always #2.5 ref_clk = ~ref_clk;
   flowthrough_burst_sram_port #(.ADDR_W(6)) u_dut (.ref_clk(ref_clk), .srst(srst),
      .addr_hi(ah), .burst_addr_bit1(a1), .burst_addr_bit0(a0), .master_chip_en_n(m_n),
      .chip_en_hi(hi), .chip_en_lo_n(lo_n), .proc_addr_strobe_n(p_n),
      .ctrl_addr_strobe_n(c_n), .burst_advance_n(adv_n), .all_bytes_write_n(gw_n),
      .byte_write_gate_n(bg_n), .byte_lane_write_n(ln_n), .output_en_n(oe_n),
      .burst_order_sel(order), .snooze_req(snz), .dq_in(dq_w), .dq_out(dq_out),
      .dq_oe(dq_oe), .snooze_active(snz_act));
   sram_bus_partner u_far (.ref_clk(ref_clk), .dq_oe(dq_oe), .dq_out(dq_out),
      .drv_en(drv_en), .drv_data(drv_d), .dq_wire(dq_w), .clash(clash));
   // Linear feedback shift register step
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Low address bits of a beat: xor when interleaved, add when linear
   function automatic logic [1:0] beat(input logic [1:0] s, input logic [1:0] k, input logic il);
      return il ? (s ^ k) : (s + k);
   endfunction
   // Word after a write with controls {global, gate, lane1, lane0}
   function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] n,
                                         input logic [3:0] w);
      if (!w[3]) return n;
      if (w[2]) return o;
      return {w[1] ? o[17:9] : n[17:9], w[0] ? o[8:0] : n[8:0]};
   endfunction
   // Compare and count
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One command at a rising edge; returns at the falling edge before it is taken
   task automatic step(input logic [1:0] s, input logic [2:0] e, input logic v,
                       input logic [3:0] w, input logic [5:0] a, input logic [17:0] d);
      @(posedge ref_clk);
      {p_n, c_n, m_n, hi, lo_n, adv_n, gw_n, bg_n, ln_n, ah, a1, a0, drv_d} <= {s, e, v, w, a, d};
      // Data driven only when the controls really ask for a write
      drv_en <= s[1] && (!w[3] || (!w[2] && !(&w[1:0])));
      @(negedge ref_clk);
   endtask
   // Controller-strobe write with processor strobe held high
   task automatic wr(input logic [5:0] a, input logic [3:0] w);
      rnd = lfsr(rnd);
      mem[a] = merge(mem[a], rnd[17:0], w);
      step(2'h2, EN, 1'b1, w, a, rnd[17:0]);
   endtask
   // Verdict and end of run
   task automatic test_done;
      if (n_fail == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Main sequence: fill, random bursts both orders, snooze
   initial begin
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      for (int i = 0; i < 64; i++) wr(i[5:0], 4'h7);
      for (int p = 0; p < 8; p++) begin
         @(posedge ref_clk) order <= p[0];
         rnd = lfsr(rnd);
         base = rnd[5:0] & 6'h3C;
         st = rnd[7:6];
         // Always a write, so no read turns the bus before the next write
         for (int k = 0; k < 4; k++) wr(base | k[5:0], {rnd[21], 1'b0, rnd[19], 1'b0});
         step(2'h2, (p % 3 == 0) ? 3'h6 : ((p % 3 == 1) ? 3'h0 : 3'h3), 1'b1, 4'hF, 6'h0, 18'h0);
         chk({17'h0, dq_oe}, 18'h0);
         step(2'h1, EN, 1'b0, 4'h0, base | st, 18'h0);
         chk({17'h0, dq_oe}, 18'h0);
         for (int k = 1; k < 4; k++) begin
            step(2'h3, 3'h6, 1'b0, 4'hF, rnd[13:8], 18'h0);
            chk(dq_out, mem[base | beat(st, 2'(k - 1), p[0])]);
            chk({17'h0, dq_oe}, 18'h1);
         end
         step(2'h3, EN, 1'b1, 4'hF, 6'h0, 18'h0);
         chk(dq_out, mem[base | beat(st, 2'h3, p[0])]);
         step(2'h2, 3'h6, 1'b1, 4'hF, 6'h0, 18'h0);
         chk(dq_out, mem[base | beat(st, 2'h3, p[0])]);
         step(2'h1, 3'h6, 1'b1, 4'hF, 6'h0, 18'h0);
         chk({17'h0, dq_oe}, 18'h0);
         step(2'h3, EN, 1'b1, 4'hF, 6'h0, 18'h0);
         chk({17'h0, dq_oe}, 18'h0);
      end
      step(2'h1, EN, 1'b1, 4'hF, 6'h05, 18'h0);
      @(posedge ref_clk) snz <= 1'b1;
      repeat (3) step(2'h3, EN, 1'b1, 4'hF, 6'h0, 18'h0);
      chk({17'h0, snz_act}, 18'h1);
      step(2'h2, EN, 1'b1, 4'h7, 6'h05, 18'h3FFFF);
      chk({17'h0, dq_oe}, 18'h0);
      @(posedge ref_clk) snz <= 1'b0;
      repeat (3) step(2'h2, 3'h6, 1'b1, 4'hF, 6'h0, 18'h0);
      step(2'h1, EN, 1'b1, 4'hF, 6'h05, 18'h0);
      step(2'h3, EN, 1'b1, 4'hF, 6'h0, 18'h0);
      chk(dq_out, mem[5]);
      chk({17'h0, clash}, 18'h0);
      test_done();
   end
   // Watchdog well beyond the expected run
   initial begin
      #20000;
      n_fail++;
      test_done();
   end
endmodule
`default_nettype wire
